/* File: design/device_control_command.v */
// Target-side decoder for the broadcast device-control common command
// Notes on behaviour
// R1: Mode 000 acts only when all seven identifier bits equal own address.
// R2: Mode 011 acts when identifier bits 6..3 equal the local type code.
// R3: Mode 111 always acts, identifier value ignored.
// R4: Any other mode is reserved and the command is not acknowledged.
// R5: With register select 0, first-byte select picks the first general byte.
// R6: Each further payload byte goes to the next general byte until STOP.
// R7: Host stops after general byte 3 and sends no more payload.
// R8: With PEC on, PEC byte follows burst length 1..4 data bytes.
// R9: Register select 0 steers payload into the four general bytes.
// R10: Register select 1 steers payload to device offsets, ignoring select and burst.
// R11: Host never mixes register select 1 with broadcast on mixed buses.
// R12: General byte 0 bit 7 sets PEC enable, bit 6 parity enable.
// R13: General byte 0 bit 1 is ignored.
// R14: General byte 1 bit 3 set clears all events and pending interrupt.
// R15: Events still present after a clear set again and interrupt anew.
// R16: PEC covers from START but excludes the broadcast address byte.
// R17: Identifier mismatch with good parity skips parity, discards until STOP/Sr.
// R18: PEC-protected form is accepted only in I3C Basic mode.
// R19: Control byte: mode 7..5, first select 4..3, burst 2..1, register select 0.
// R20: Writes to reserved bits, bytes 2 and 3 included, change nothing.
`timescale 1ns/1ns
`default_nettype none
`include "device_control_command_map.vh"
module device_control_command #(
  parameter SYNC_STAGES = 2
) (
  input wire clk,
  input wire reset_n,
  input wire startToggle,
  input wire stopToggle,
  input wire byteToggle,
  input wire [7:0] byteData,
  input wire idParityOk,
  input wire i3cMode,
  input wire [3:0] localTypeCode,
  input wire [2:0] hostAssignedCode,
  output reg commandAccepted,
  output reg commandNack,
  output reg skipParityCheck,
  output reg pecByteNext,
  output reg pecCheck,
  output reg pecInclude,
  output reg eventClear,
  output reg offsetWriteValid,
  output reg [7:0] offsetWriteData,
  output reg pecEnable,
  output reg parityEnable
);
  localparam S_IDLE = 3'h0;
  localparam S_CTRL = 3'h1;
  localparam S_ID = 3'h2;
  localparam S_DATA = 3'h3;
  localparam S_PEC = 3'h4;
  localparam S_SKIP = 3'h5;

  // Address match decision for one identifier byte
  function match;
    input [2:0] mode;
    input [7:0] idByte;
    input [3:0] typeCode;
    input [2:0] hostCode;
    begin
      case (mode)
        `MODE_UNICAST: match = (idByte[`ID_HI:`ID_LO] == {typeCode, hostCode}); // see R1
        `MODE_MULTICAST: match = (idByte[`ID_TYPE_HI:`ID_TYPE_LO] == typeCode); // see R2
        `MODE_BROADCAST: match = 1'b1; // see R3
        default: match = 1'b0; // see R4
      endcase
    end
  endfunction

  // Recognised address match modes; the rest are reserved
  function modeKnown;
    input [2:0] sel;
    begin
      modeKnown = (sel == `MODE_UNICAST) || (sel == `MODE_MULTICAST)
        || (sel == `MODE_BROADCAST);
    end
  endfunction

  // SYNC_STAGES-flop toggle synchronisers, two flops for data and parity; the link events arrive as toggles from the bus clock
  reg [SYNC_STAGES-1:0] syncStart;
  reg [SYNC_STAGES-1:0] syncStop;
  reg [SYNC_STAGES-1:0] syncByte;
  reg [7:0] dataMeta;
  reg [7:0] dataSync;
  reg parityMeta;
  reg paritySync;
  reg lastStart;
  reg lastStop;
  reg lastByte;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncStart <= {SYNC_STAGES{1'b0}};
      syncStop <= {SYNC_STAGES{1'b0}};
      syncByte <= {SYNC_STAGES{1'b0}};
      dataMeta <= 8'h00;
      dataSync <= 8'h00;
      parityMeta <= 1'b0;
      paritySync <= 1'b0;
      lastStart <= 1'b0;
      lastStop <= 1'b0;
      lastByte <= 1'b0;
    end else begin
      syncStart <= {syncStart[SYNC_STAGES-2:0], startToggle};
      syncStop <= {syncStop[SYNC_STAGES-2:0], stopToggle};
      syncByte <= {syncByte[SYNC_STAGES-2:0], byteToggle};
      dataMeta <= byteData;
      dataSync <= dataMeta;
      parityMeta <= idParityOk;
      paritySync <= parityMeta;
      lastStart <= syncStart[SYNC_STAGES-1];
      lastStop <= syncStop[SYNC_STAGES-1];
      lastByte <= syncByte[SYNC_STAGES-1];
    end
  end

  wire startEvent = syncStart[SYNC_STAGES-1] ^ lastStart;
  wire stopEvent = syncStop[SYNC_STAGES-1] ^ lastStop;
  wire byteEvent = syncByte[SYNC_STAGES-1] ^ lastByte;

  reg [2:0] state;
  reg [2:0] mode;
  reg regSelect;
  reg [1:0] generalIndex;
  reg [1:0] burstLeft;
  reg pecActive;
  reg generalDone;

  // Command sequencer; STOP or repeated START always ends a frame
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      mode <= `MODE_UNICAST;
      regSelect <= 1'b0;
      generalIndex <= 2'h0;
      burstLeft <= 2'h0;
      pecActive <= 1'b0;
      generalDone <= 1'b0;
      commandAccepted <= 1'b0;
      commandNack <= 1'b0;
      skipParityCheck <= 1'b0;
      pecByteNext <= 1'b0;
      pecCheck <= 1'b0;
      pecInclude <= 1'b0;
      eventClear <= 1'b0;
      offsetWriteValid <= 1'b0;
      offsetWriteData <= 8'h00;
      pecEnable <= `RST_PEC_EN;
      parityEnable <= `RST_PARITY_EN;
    end else begin
      pecCheck <= 1'b0;
      pecInclude <= 1'b0;
      eventClear <= 1'b0; // One pulse; the event owner re-sets if still present, see R15
      offsetWriteValid <= 1'b0;
      if (stopEvent || startEvent) begin
        state <= startEvent ? S_CTRL : S_IDLE;
        commandAccepted <= 1'b0;
        commandNack <= 1'b0;
        skipParityCheck <= 1'b0;
        pecByteNext <= 1'b0;
        generalDone <= 1'b0;
      end else if (byteEvent) begin
        // Body bytes count toward PEC until the frame is discarded; the front end withholds 0x7E/W, see R16
        pecInclude <= (state != S_IDLE) && (state != S_SKIP);
        case (state)
          S_CTRL: begin
            mode <= dataSync[`CTRL_MODE_HI:`CTRL_MODE_LO]; // see R19
            regSelect <= dataSync[`CTRL_REGSEL]; // see R9
            generalIndex <= dataSync[`CTRL_FIRST_HI:`CTRL_FIRST_LO]; // see R5
            burstLeft <= dataSync[`CTRL_BURST_HI:`CTRL_BURST_LO]; // see R8
            pecActive <= pecEnable & i3cMode; // see R18
            state <= S_ID;
          end
          S_ID: begin
            if (match(mode, dataSync, localTypeCode, hostAssignedCode)) begin
              commandAccepted <= 1'b1;
              state <= S_DATA;
              pecByteNext <= 1'b0;
            end else begin
              // Reserved mode NACKs; a plain mismatch just drops out, see R4
              commandNack <= !modeKnown(mode); // see R4
              // Reserved modes NACK instead, so never skip and NACK at once
              skipParityCheck <= paritySync && modeKnown(mode); // see R17
              state <= S_SKIP;
            end
          end
          S_DATA: begin
            if (regSelect) begin
              offsetWriteValid <= 1'b1; // Offset path downstream, see R10
              offsetWriteData <= dataSync;
            end else if (!generalDone) begin
              case (generalIndex)
                2'h0: begin
                  pecEnable <= dataSync[`GB0_PEC_EN]; // see R12
                  parityEnable <= dataSync[`GB0_PARITY_EN]; // bit 1 unused, see R13
                end
                2'h1: begin
                  if (dataSync[`GB1_EVENT_CLEAR]) begin
                    eventClear <= 1'b1; // see R14
                  end
                end
                default: begin
                  // Bytes 2 and 3 are reserved and leave state alone, see R20
                end
              endcase
              generalIndex <= generalIndex + 2'h1; // see R6
              // Byte 3 is last; further payload is the host's fault, see R7
              generalDone <= (generalIndex == `GB_LAST);
              if (pecActive) begin
                if (burstLeft == 2'h0) begin
                  state <= S_PEC;
                  pecByteNext <= 1'b1; // see R8
                end
                burstLeft <= burstLeft - 2'h1;
              end
            end
          end
          S_PEC: begin
            pecCheck <= 1'b1;
            pecByteNext <= 1'b0;
            state <= S_SKIP;
          end
          default: state <= state; // Idle or discarding until STOP/Sr
        endcase
      end
    end
  end
endmodule // device_control_command
`default_nettype wire

/* File: design/device_control_command_map.vh */
// Field positions, codes and reset values for the device-control command decoder
`ifndef DEVICE_CONTROL_COMMAND_MAP_VH
`define DEVICE_CONTROL_COMMAND_MAP_VH
// Control byte fields
`define CTRL_MODE_HI 7
`define CTRL_MODE_LO 5
`define CTRL_FIRST_HI 4
`define CTRL_FIRST_LO 3
`define CTRL_BURST_HI 2
`define CTRL_BURST_LO 1
`define CTRL_REGSEL 0
// Address match modes
`define MODE_UNICAST 3'h0
`define MODE_MULTICAST 3'h3
`define MODE_BROADCAST 3'h7
// Identifier byte fields (identifier sits in bits 7..1)
`define ID_HI 7
`define ID_LO 1
`define ID_TYPE_HI 7
`define ID_TYPE_LO 4
// General byte 0 and 1 fields, and the index of the last general byte
`define GB0_PEC_EN 7
`define GB0_PARITY_EN 6
`define GB1_EVENT_CLEAR 3
`define GB_LAST 2'h3
// Reset values of the bus configuration bits
`define RST_PEC_EN 1'h0
`define RST_PARITY_EN 1'h1
`endif

/* File: dv/device_control_command_props.sv */
// Output checker for the device-control command decoder
`timescale 1ns/1ns
`default_nettype none
module device_control_command_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic i3cMode,
  input wire logic commandAccepted,
  input wire logic commandNack,
  input wire logic skipParityCheck,
  input wire logic pecByteNext,
  input wire logic pecCheck,
  input wire logic pecInclude,
  input wire logic eventClear,
  input wire logic offsetWriteValid,
  input wire logic pecEnable,
  input wire logic parityEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A clear must be a single-cycle strobe
  sequence oneShot;
    eventClear ##1 !eventClear;
  endsequence
  clear_once_a: assert property (eventClear |-> oneShot)
    else $error("clear strobe too long");
  clear_owner_a: assert property (eventClear |-> commandAccepted)
    else $error("clear without accepted command");
  offset_owner_a: assert property (offsetWriteValid |-> commandAccepted)
    else $error("offset write without match");
  offset_excl_a: assert property (offsetWriteValid |-> !eventClear)
    else $error("offset write also hit general byte");
  accept_excl_a: assert property (commandAccepted |-> !commandNack && !skipParityCheck)
    else $error("accepted with nack or skip");
  nack_excl_a: assert property (commandNack |-> !skipParityCheck)
    else $error("nack with skip");
  cfg_cause_a: assert property ($changed({pecEnable, parityEnable}) |-> $past(commandAccepted))
    else $error("config changed without command");
  pec_gate_a: assert property (pecByteNext |-> i3cMode && commandAccepted)
    else $error("checksum byte outside I3C");
  pec_once_a: assert property (pecCheck |=> !pecCheck && !pecByteNext)
    else $error("checksum check repeated");
  pec_covered_a: assert property (pecCheck |-> pecInclude)
    else $error("checksum byte left out of checksum");
endmodule // device_control_command_props
bind device_control_command device_control_command_props device_control_command_props_i (
  .clk, .reset_n, .i3cMode, .commandAccepted, .commandNack, .skipParityCheck, .pecByteNext,
  .pecCheck, .pecInclude, .eventClear, .offsetWriteValid, .pecEnable, .parityEnable);
`default_nettype wire

/* File: dv/bus_host_model.sv */
// Bus host model: one START, byte or STOP event per 800 ns link period
`timescale 1ns/1ns
`default_nettype none
module bus_host_model (
  input wire logic clk,
  output logic startToggle = 1'b0,
  output logic stopToggle = 1'b0,
  output logic byteToggle = 1'b0,
  output logic [7:0] byteData = 8'h00,
  output logic idParityOk = 1'b1
);
  // Data settles 4 clk before the flip; between bytes it is not held
  // Kind: 0 START, 1 STOP, 2 byte, 3 byte with bad parity
  task automatic ev(input int k, input logic [7:0] d);
    byteData = (k >= 2) ? d : ~byteData;
    idParityOk = (k != 3);
    repeat (4) @(posedge clk);
    #1;
    if (k == 0) startToggle = !startToggle;
    if (k == 1) stopToggle = !stopToggle;
    if (k >= 2) byteToggle = !byteToggle;
    repeat (4) @(posedge clk);
    #1;
  endtask
endmodule // bus_host_model
`default_nettype wire

/* File: dv/device_control_command_tb.sv */
// Self-checking bench: random command frames through the host model
`timescale 1ns/1ns
`default_nettype none
module device_control_command_tb;
  logic clk = 1'b0, reset_n = 1'b0, i3cMode = 1'b0, hit, ok, pe = 1'b0, pa = 1'b1;
  logic [3:0] localTypeCode = 4'h9;
  logic [2:0] hostAssignedCode = 3'h5;
  logic [7:0] c, id, d0, d1;
  logic bad, pOn;
  logic [7:0] lastOff = 8'h00;
  int nChk = 0, nInc = 0, eK, eI, nD;
  wire logic startToggle, stopToggle, byteToggle, idParityOk, commandAccepted, commandNack;
  wire logic skipParityCheck, pecByteNext, pecCheck, pecInclude, eventClear, offsetWriteValid;
  wire logic pecEnable, parityEnable;
  wire logic [7:0] byteData, offsetWriteData;
  int failures = 0, samples_checked = 0, seed = 51, nClr = 0, nOff = 0, eC, eO;
  device_control_command device_control_command_i (.clk, .reset_n, .startToggle, .stopToggle,
    .byteToggle, .byteData, .idParityOk, .i3cMode, .localTypeCode, .hostAssignedCode,
    .commandAccepted, .commandNack, .skipParityCheck, .pecByteNext, .pecCheck, .pecInclude,
    .eventClear, .offsetWriteValid, .offsetWriteData, .pecEnable, .parityEnable);
  bus_host_model bus_host_model_i (.clk, .startToggle, .stopToggle, .byteToggle, .byteData,
    .idParityOk);
  initial forever #50 clk = ~clk;
  // Strobe counters, diffed per frame
  always @(posedge clk) begin
    if (eventClear === 1'b1) nClr++;
    if (offsetWriteValid === 1'b1) nOff++;
    if (offsetWriteValid === 1'b1) lastOff = offsetWriteData;
    if (pecCheck === 1'b1) nChk++;
    if (pecInclude === 1'b1) nInc++;
  end
  function automatic logic match(input logic [2:0] m, input logic [7:0] v);
    case (m)
      3'h0: return v[7:1] == {localTypeCode, hostAssignedCode};
      3'h3: return v[7:4] == localTypeCode;
      3'h7: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard, far beyond 40 frames of 6 link periods
  initial begin
    #2000000;
    failures++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 reset_n = 1'b1;
    chk("pecEnable", pe, pecEnable);
    chk("parityEnable", pa, parityEnable);
    for (int i = 0; i < 40; i++) begin
      c = $random(seed);
      if (i < 8) c[7:5] = i[2:0];
      if (c[7:5] == 3'h7) c[0] = 1'b0;
      id = $random(seed);
      if (i[0]) id[7:4] = localTypeCode;
      if (i[1]) id[3:1] = hostAssignedCode;
      d0 = $random(seed);
      d1 = $random(seed);
      i3cMode = 1'($random(seed));
      // Corner cases: turn PEC on, then a PEC byte, then a PEC byte left pending
      if (i >= 8 && i < 11) begin
        c = (i == 10) ? 8'hE2 : 8'hE0;
        d0[7] = 1'b1;
        i3cMode = (i != 8);
      end
      ok = c[7:5] inside {3'h0, 3'h3, 3'h7};
      hit = match(c[7:5], id);
      bad = !hit && d1[0];
      pOn = pe && i3cMode;
      nD = (c[4:3] != 2'h3 || c[0]) ? 2 : 1;
      eC = nClr;
      eO = nOff;
      eK = nChk;
      eI = nInc;
      bus_host_model_i.ev(0, 8'h00);
      bus_host_model_i.ev(2, c);
      bus_host_model_i.ev(bad ? 3 : 2, id);
      chk("commandAccepted", hit, commandAccepted);
      chk("commandNack", !ok, commandNack);
      chk("skipParityCheck", ok && !hit && !bad, skipParityCheck);
      bus_host_model_i.ev(2, d0);
      if (nD == 2) bus_host_model_i.ev(2, d1);
      chk("pecByteNext", pOn && hit && !c[0] && nD == c[2:1] + 1, pecByteNext);
      bus_host_model_i.ev(1, 8'h00);
      if (hit && !c[0] && c[4:3] == 2'h0) {pe, pa} = d0[7:6];
      chk("pecEnable", pe, pecEnable);
      chk("parityEnable", pa, parityEnable);
      chk("eventClear", hit && !c[0] && (c[4:3] == 2'h0 && d1[3] && !(pOn && c[2:1] == 2'h0)
        || c[4:3] == 2'h1 && d0[3]), nClr - eC);
      chk("offsetWriteValid", (hit && c[0]) ? 2 : 0, nOff - eO);
      if (hit && c[0]) chk("offsetWriteData", d1, lastOff);
      chk("pecCheck", pOn && hit && !c[0] && c[2:1] == 2'h0 && nD == 2, nChk - eK);
      chk("pecInclude", hit ? 2 + nD : 2, nInc - eI);
      chk("commandAccepted", 0, commandAccepted);
    end
    final_report;
  end
endmodule // device_control_command_tb
`default_nettype wire
